//--- hw/pwmd_pkg.sv
// Operation
// - Duty interval is the time a channel output is driven high.
// - Period starts at counter zero; delay runs from there to rising edge.
// - Period counter length is selectable, at most sixteen bits.
// - Each channel pulses a conversion trigger at a configurable count.
// - Channels are individually indexed, 00 up to 95 at most.
// - Pending trigger channel numbers are held in eight entries, 0 to 7.
// - Four frame-clock dividers and four period settings, indexed 0 to 3.
// - Next conversion trigger waits for the previous conversion end.
// - Result is stored per triggering channel on the conversion end.
// - Result differing from the channel reference raises an error interrupt.
// - Divider compares its 11-bit counter each cycle, toggles and clears.
// - Output rises on rising-edge match, falls on falling-edge match.
// - Bit 16 of the falling-edge value forces a constant high output.
// - Equal rising and falling values give a constant low output.
package pwmd_pkg;

  // ****************************************
  // Structure
  // ****************************************
  localparam int unsigned PWMD_MAX_CH = 96;
  localparam int unsigned PWMD_NUM_FRAME = 4;
  localparam int unsigned PWMD_SEL_W = 2;
  localparam int unsigned PWMD_DIV_W = 11;
  localparam int unsigned PWMD_CNT_W = 16;
  localparam int unsigned PWMD_EDGE_W = 17;
  localparam int unsigned PWMD_FULL_DUTY_BIT = 16;
  localparam int unsigned PWMD_QUEUE_DEPTH = 8;
  localparam int unsigned PWMD_RES_W = 12;

  // ****************************************
  // Reset and step values
  // ****************************************
  localparam logic [PWMD_DIV_W-1:0] PWMD_DIV_ZERO = 11'h000;
  localparam logic [PWMD_DIV_W-1:0] PWMD_DIV_ONE = 11'h001;
  localparam logic [PWMD_CNT_W-1:0] PWMD_CNT_ZERO = 16'h0000;
  localparam logic [PWMD_CNT_W-1:0] PWMD_CNT_ONE = 16'h0001;

endpackage

//--- hw/pwmd_frame_clock_divider.sv
`timescale 1ns/1ps
module pwmd_frame_clock_divider (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [pwmd_pkg::PWMD_NUM_FRAME-1:0] enable_i,
  input wire logic [pwmd_pkg::PWMD_NUM_FRAME-1:0]
    [pwmd_pkg::PWMD_DIV_W-1:0] compare_i,
  output logic [pwmd_pkg::PWMD_NUM_FRAME-1:0] frame_clock_out_o,
  output logic [pwmd_pkg::PWMD_NUM_FRAME-1:0] frame_tick_o
);
  import pwmd_pkg::*;

  typedef struct packed {
    logic [PWMD_NUM_FRAME-1:0][PWMD_DIV_W-1:0] cnt;
    logic [PWMD_NUM_FRAME-1:0] fclk;
    logic [PWMD_NUM_FRAME-1:0] tick;
  } pwmd_div_state_t;

  pwmd_div_state_t state_reg;
  pwmd_div_state_t state_next;

  // ****************************************
  // Divider chains
  // ****************************************
  always_comb begin
    state_next = state_reg;
    for (int m = 0; m < PWMD_NUM_FRAME; m++) begin
      state_next.tick[m] = 1'b0;
      if (!enable_i[m]) begin
        state_next.cnt[m] = PWMD_DIV_ZERO;
        state_next.fclk[m] = 1'b0;
      end else if (compare_i[m] == PWMD_DIV_ZERO) begin
        // Zero means full rate: one tick every input clock
        state_next.cnt[m] = PWMD_DIV_ZERO;
        state_next.fclk[m] = ~state_reg.fclk[m];
        state_next.tick[m] = 1'b1;
      end else if (state_reg.cnt[m] == compare_i[m] - PWMD_DIV_ONE) begin
        // Match ends a half period of compare cycles
        state_next.cnt[m] = PWMD_DIV_ZERO;
        state_next.fclk[m] = ~state_reg.fclk[m];
        state_next.tick[m] = ~state_reg.fclk[m];
      end else begin
        state_next.cnt[m] = state_reg.cnt[m] + PWMD_DIV_ONE;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign frame_clock_out_o = state_reg.fclk;
  assign frame_tick_o = state_reg.tick;

endmodule

//--- hw/pwmd_top.sv
`timescale 1ns/1ps
module pwmd_top #(
  parameter int unsigned NUM_CH = pwmd_pkg::PWMD_MAX_CH,
  parameter int unsigned QUEUE_DEPTH = pwmd_pkg::PWMD_QUEUE_DEPTH,
  parameter int unsigned RES_W = pwmd_pkg::PWMD_RES_W,
  parameter int unsigned CH_W = $clog2(NUM_CH)
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [pwmd_pkg::PWMD_NUM_FRAME-1:0] frame_enable_i,
  input wire logic [pwmd_pkg::PWMD_NUM_FRAME-1:0]
    [pwmd_pkg::PWMD_DIV_W-1:0] frame_compare_i,
  input wire logic [pwmd_pkg::PWMD_NUM_FRAME-1:0]
    [pwmd_pkg::PWMD_CNT_W-1:0] period_value_i,
  input wire logic [NUM_CH-1:0][pwmd_pkg::PWMD_SEL_W-1:0] period_sel_i,
  input wire logic [NUM_CH-1:0][pwmd_pkg::PWMD_CNT_W-1:0] rise_edge_value_i,
  input wire logic [NUM_CH-1:0][pwmd_pkg::PWMD_EDGE_W-1:0] fall_edge_value_i,
  input wire logic [NUM_CH-1:0][pwmd_pkg::PWMD_CNT_W-1:0] trigger_value_i,
  input wire logic [NUM_CH-1:0] trigger_enable_i,
  input wire logic [NUM_CH-1:0][RES_W-1:0] reference_value_i,
  input wire logic conv_end_i,
  input wire logic [RES_W-1:0] conv_result_i,
  output logic [pwmd_pkg::PWMD_NUM_FRAME-1:0] frame_clock_out_o,
  output logic [NUM_CH-1:0] pwm_o,
  output logic conv_start_o,
  output logic [CH_W-1:0] conv_channel_o,
  output logic [NUM_CH-1:0][RES_W-1:0] channel_result_o,
  output logic error_irq_o,
  output logic [CH_W-1:0] error_channel_o,
  output logic queue_full_o
);
  import pwmd_pkg::*;

  // Pointers wrap by overflow, so the depth must be a power of two
  localparam int unsigned PTR_W = $clog2(QUEUE_DEPTH);
  localparam int unsigned LVL_W = PTR_W + 1;
  localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);
  localparam logic [LVL_W-1:0] LVL_ONE = LVL_W'(1);
  localparam logic [LVL_W-1:0] LVL_FULL = LVL_W'(QUEUE_DEPTH);
  localparam logic [LVL_W-1:0] LVL_ZERO = '0;

  typedef struct packed {
    logic [PWMD_NUM_FRAME-1:0][PWMD_CNT_W-1:0] pcnt;
    logic [NUM_CH-1:0] out;
    logic [NUM_CH-1:0] pend;
    logic [QUEUE_DEPTH-1:0][CH_W-1:0] slots;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [LVL_W-1:0] level;
    logic full;
    logic busy;
    logic [CH_W-1:0] cur_ch;
    logic start;
    logic [NUM_CH-1:0][RES_W-1:0] result;
    logic err;
    logic [CH_W-1:0] err_ch;
  } pwmd_top_state_t;

  pwmd_top_state_t state_reg;
  pwmd_top_state_t state_next;
  logic [PWMD_NUM_FRAME-1:0] frame_tick;

  // ****************************************
  // Helpers
  // ****************************************
  // Lowest index wins so that arbitration is fixed and repeatable
  function automatic logic [CH_W-1:0] lowest_set(
    input logic [NUM_CH-1:0] vec
  );
    logic [CH_W-1:0] idx;
    idx = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (vec[i]) begin
        idx = CH_W'(i);
      end
    end
    return idx;
  endfunction

  function automatic logic [PWMD_CNT_W-1:0] count_step(
    input logic [PWMD_CNT_W-1:0] cnt,
    input logic [PWMD_CNT_W-1:0] period
  );
    logic [PWMD_CNT_W-1:0] nxt;
    nxt = (cnt == period) ? PWMD_CNT_ZERO : cnt + PWMD_CNT_ONE;
    return nxt;
  endfunction

  // ****************************************
  // Frame clocks
  // ****************************************
  pwmd_frame_clock_divider u_frame_clock_divider (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .enable_i(frame_enable_i),
    .compare_i(frame_compare_i),
    .frame_clock_out_o(frame_clock_out_o),
    .frame_tick_o(frame_tick)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [NUM_CH-1:0] trig_vec;
    logic [NUM_CH-1:0] push_mask;
    logic [CH_W-1:0] push_ch;
    logic [PWMD_CNT_W-1:0] cur;
    logic tk;
    logic push;
    logic pop;
    trig_vec = '0;
    push_mask = '0;
    push_ch = '0;
    cur = PWMD_CNT_ZERO;
    tk = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    state_next = state_reg;
    state_next.start = 1'b0;
    state_next.err = 1'b0;

    // ****************************************
    // Period counters
    // ****************************************
    // Period counters, one per setting, each on its own frame clock
    for (int m = 0; m < PWMD_NUM_FRAME; m++) begin
      if (frame_tick[m]) begin
        state_next.pcnt[m] = count_step(state_reg.pcnt[m],
          period_value_i[m]);
      end
    end

    // ****************************************
    // Channel waveforms
    // ****************************************
    // Channel waveforms; compares use the count just reached
    for (int c = 0; c < NUM_CH; c++) begin
      cur = state_next.pcnt[period_sel_i[c]];
      tk = frame_tick[period_sel_i[c]];
      if (fall_edge_value_i[c][PWMD_FULL_DUTY_BIT]) begin
        state_next.out[c] = 1'b1;
      end else if (fall_edge_value_i[c][PWMD_CNT_W-1:0]
          == rise_edge_value_i[c]) begin
        state_next.out[c] = 1'b0;
      end else if (tk && cur == rise_edge_value_i[c]) begin
        state_next.out[c] = 1'b1;
      end else if (tk && cur == fall_edge_value_i[c][PWMD_CNT_W-1:0]) begin
        state_next.out[c] = 1'b0;
      end
      trig_vec[c] = tk && trigger_enable_i[c]
        && cur == trigger_value_i[c];
    end

    // ****************************************
    // Trigger queue
    // ****************************************
    // Move the lowest pending channel into the queue when room exists
    push = (state_reg.pend != '0) && (state_reg.level != LVL_FULL);
    push_ch = lowest_set(state_reg.pend);
    if (push) begin
      push_mask[push_ch] = 1'b1;
      state_next.slots[state_reg.wr_ptr] = push_ch;
      state_next.wr_ptr = state_reg.wr_ptr + PTR_ONE;
    end
    // A new trigger wins over the clear of the same pending bit
    state_next.pend = (state_reg.pend & ~push_mask) | trig_vec;

    // ****************************************
    // Conversion control
    // ****************************************
    // Only one conversion in flight at a time
    pop = !state_reg.busy && (state_reg.level != LVL_ZERO);
    if (pop) begin
      state_next.start = 1'b1;
      state_next.cur_ch = state_reg.slots[state_reg.rd_ptr];
      state_next.rd_ptr = state_reg.rd_ptr + PTR_ONE;
      state_next.busy = 1'b1;
    end

    if (push && !pop) begin
      state_next.level = state_reg.level + LVL_ONE;
    end else if (pop && !push) begin
      state_next.level = state_reg.level - LVL_ONE;
    end
    // Kept as a flop so the full output needs no decode after the register
    state_next.full = (state_next.level == LVL_FULL);

    // Conversion end stores the result and frees the next trigger
    // A stray end pulse with nothing in flight is ignored
    if (state_reg.busy && conv_end_i) begin
      state_next.busy = 1'b0;
      state_next.result[state_reg.cur_ch] = conv_result_i;
      if (conv_result_i != reference_value_i[state_reg.cur_ch]) begin
        state_next.err = 1'b1;
        state_next.err_ch = state_reg.cur_ch;
      end
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign pwm_o = state_reg.out;
  assign conv_start_o = state_reg.start;
  assign conv_channel_o = state_reg.cur_ch;
  assign channel_result_o = state_reg.result;
  assign error_irq_o = state_reg.err;
  assign error_channel_o = state_reg.err_ch;
  assign queue_full_o = state_reg.full;

endmodule

//--- verification/pwmd_props.sv
`timescale 1ns/1ps
// ****
// Checker
// ****
module pwmd_props #(
  parameter int unsigned NUM_CH = 96,
  parameter int unsigned RES_W = 12,
  parameter int unsigned CH_W = 7
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [pwmd_pkg::PWMD_NUM_FRAME-1:0] frame_enable_i,
  input wire logic [NUM_CH-1:0][pwmd_pkg::PWMD_CNT_W-1:0] rise_edge_value_i,
  input wire logic [NUM_CH-1:0][pwmd_pkg::PWMD_EDGE_W-1:0] fall_edge_value_i,
  input wire logic [NUM_CH-1:0][RES_W-1:0] reference_value_i,
  input wire logic conv_end_i,
  input wire logic [RES_W-1:0] conv_result_i,
  input wire logic [pwmd_pkg::PWMD_NUM_FRAME-1:0] frame_clock_out_o,
  input wire logic [NUM_CH-1:0] pwm_o,
  input wire logic conv_start_o,
  input wire logic [CH_W-1:0] conv_channel_o,
  input wire logic [NUM_CH-1:0][RES_W-1:0] channel_result_o,
  input wire logic error_irq_o,
  input wire logic [CH_W-1:0] error_channel_o
);
  import pwmd_pkg::*;
  logic busy_reg;
  logic bad;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Conversion in flight, tracked from the ports alone
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      busy_reg <= 1'b0;
    end else if (conv_start_o) begin
      busy_reg <= 1'b1;
    end else if (conv_end_i) begin
      busy_reg <= 1'b0;
    end
  end
  assign bad = conv_end_i && busy_reg &&
    conv_result_i != reference_value_i[conv_channel_o];
  a_start_pulse:
    assert property (conv_start_o |=> !conv_start_o) else $error("long start");
  a_start_waits:
    assert property (conv_start_o |-> !busy_reg) else $error("start busy");
  a_result_stored:
    assert property (conv_end_i && busy_reg |=>
      channel_result_o[conv_channel_o] == $past(conv_result_i))
      else $error("result lost");
  a_error_raised:
    assert property (bad |=> error_irq_o &&
      error_channel_o == $past(conv_channel_o)) else $error("no error");
  a_error_cause:
    assert property (!bad |=> !error_irq_o) else $error("stray error");
  a_full_duty:
    assert property (fall_edge_value_i[1][16] [*2] |-> pwm_o[1])
      else $error("full duty low");
  a_zero_duty:
    assert property ((rise_edge_value_i[2] == fall_edge_value_i[2][15:0] &&
      !fall_edge_value_i[2][16]) [*2] |-> !pwm_o[2])
      else $error("zero duty high");
  a_frame_off:
    assert property (!frame_enable_i[3] |=> !frame_clock_out_o[3])
      else $error("frame clock off");
  c_start: cover property (conv_start_o);
  c_error: cover property (error_irq_o);
  c_rise: cover property ($rose(pwm_o[0]));
endmodule

bind pwmd_top pwmd_props #(.NUM_CH(NUM_CH), .RES_W(RES_W), .CH_W(CH_W))
  i_pwmd_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .frame_enable_i(frame_enable_i), .rise_edge_value_i(rise_edge_value_i),
  .fall_edge_value_i(fall_edge_value_i), .conv_end_i(conv_end_i),
  .reference_value_i(reference_value_i), .conv_result_i(conv_result_i),
  .frame_clock_out_o(frame_clock_out_o), .pwm_o(pwm_o),
  .conv_start_o(conv_start_o), .conv_channel_o(conv_channel_o),
  .channel_result_o(channel_result_o), .error_irq_o(error_irq_o),
  .error_channel_o(error_channel_o));

//--- verification/pwmd_adc_model.sv
`timescale 1ns/1ps
module pwmd_adc_model (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  input wire logic [1:0] channel_i,
  input wire logic [7:0] delay_i,
  output logic end_o,
  output logic [11:0] result_o
);
  logic busy_reg;
  logic [7:0] cnt_reg;
  logic [1:0] ch_reg;
  always_ff @(posedge clk_i) begin
    end_o <= 1'b0;
    // Result is not held, so a late read sees garbage
    result_o <= ~result_o;
    if (sys_rst_i) begin
      busy_reg <= 1'b0;
      result_o <= 12'h000;
    end else if (start_i) begin
      busy_reg <= 1'b1;
      cnt_reg <= delay_i;
      ch_reg <= channel_i;
    end else if (busy_reg && cnt_reg == 8'h00) begin
      busy_reg <= 1'b0;
      end_o <= 1'b1;
      result_o <= 12'h100 + {10'h000, ch_reg};
    end else begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end
endmodule

//--- verification/tb.sv
`timescale 1ns/1ps
module tb;
  import pwmd_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] fen, fclk, ten, pwm;
  logic [3:0][10:0] fcmp;
  logic [3:0][15:0] per, rise, trg;
  logic [3:0][1:0] sel;
  logic [3:0][16:0] fall;
  logic [3:0][11:0] refv, res;
  logic [11:0] cres;
  logic [1:0] cch, ech;
  logic [7:0] dly;
  logic cend, start, irq, qfull;
  int mismatches = 0;
  int samples_checked = 0;
  pwmd_top #(.NUM_CH(4)) i_pwmd_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .frame_enable_i(fen), .frame_compare_i(fcmp), .period_value_i(per),
    .period_sel_i(sel), .rise_edge_value_i(rise), .fall_edge_value_i(fall),
    .trigger_value_i(trg), .trigger_enable_i(ten), .reference_value_i(refv),
    .conv_end_i(cend), .conv_result_i(cres), .frame_clock_out_o(fclk),
    .pwm_o(pwm), .conv_start_o(start), .conv_channel_o(cch),
    .channel_result_o(res), .error_irq_o(irq), .error_channel_o(ech),
    .queue_full_o(qfull));
  pwmd_adc_model i_pwmd_adc_model (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .start_i(start), .channel_i(cch), .delay_i(dly), .end_o(cend),
    .result_o(cres));
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic check(input string nm, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_sim();
    $display("checked %0d mismatched %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Cycles until channel 0 next rises
  task automatic wait_rise(output int g);
    for (g = 0; g < 300 && pwm[0] !== 1'b0; g++) @(negedge clk_i);
    for (g = g; g < 600 && pwm[0] !== 1'b1; g++) @(negedge clk_i);
  endtask
  task automatic t_duty();
    int c[4];
    int n;
    c = '{default:0};
    for (n = 0; n < 16; n++) begin
      @(negedge clk_i);
      for (int i = 0; i < 4; i++) c[i] += (pwm[i] === 1'b1);
    end
    check("duty", c[0], 6);
    check("full", c[1], 16);
    check("zero", c[2], 0);
    check("wrap", c[3], 10);
    wait_rise(n);
    for (n = 0; n < 20 && !(pwm[3] === 1'b1 && n > 1); n++) @(negedge clk_i);
    check("delay", n, 4);
  endtask
  task automatic t_period();
    int g;
    for (int m = 0; m < 4; m++) begin
      sel[0] = m[1:0];
      wait_rise(g);
      wait_rise(g);
      check("period", g, per[m] + 1);
    end
    sel[0] = 2'h0;
  endtask
  task automatic t_frame();
    int t[4];
    logic [3:0] p;
    t = '{default:0};
    fcmp[2] = 11'h002;
    fen[3] = 1'b0;
    repeat (8) @(negedge clk_i);
    p = fclk;
    for (int n = 0; n < 16; n++) begin
      @(negedge clk_i);
      for (int i = 0; i < 4; i++) t[i] += (fclk[i] !== p[i]);
      p = fclk;
    end
    check("fclk0", t[0], 16);
    check("fclk2", t[2], 8);
    check("fclk3", fclk[3], 0);
  endtask
  task automatic t_conv(input logic [7:0] d);
    int n;
    logic [1:0] ch;
    dly = d;
    for (int k = 0; k < 6; k++) begin
      for (n = 0; n < 400 && start !== 1'b1; n++) @(negedge clk_i);
      check("start", start, 1);
      ch = cch;
      for (n = 0; n < 400 && cend !== 1'b1; n++) @(negedge clk_i);
      check("end", cend, 1);
      @(negedge clk_i);
      check("result", res[ch], 12'h100 + ch);
      check("irq", irq, ch == 2'h3);
    end
    check("errch", ech, 2'h3);
    check("off", res[2], 0);
    if (d > 8'h10) check("full", qfull, 1);
  endtask
  initial begin
    fen = 4'hF;
    fcmp = '0;
    per = {16'h0005, 16'h000C, 16'h0009, 16'h0007};
    sel = '0;
    rise = {16'h0005, 16'h0003, 16'h0000, 16'h0001};
    fall = {17'h00002, 17'h00003, 17'h10000, 17'h00004};
    // Each enabled trigger sits inside its channel's high phase
    trg = {16'h0006, 16'h0000, 16'h0003, 16'h0002};
    ten = 4'hB;
    refv = {12'h0AA, 12'h102, 12'h101, 12'h100};
    dly = 8'h00;
    repeat (2) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (10) @(negedge clk_i);
    t_duty();
    t_period();
    t_frame();
    t_conv(8'h00);
    t_conv(8'h14);
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    end_sim();
  end
endmodule
